// ### design/pgfc_consts.vh
// constants for the group, fault and configuration register bank
`ifndef PGFC_CONSTS_VH
`define PGFC_CONSTS_VH
// command codes of the registers
`define PGFC_CMD_GROUP_CFG 8'hD3
`define PGFC_CMD_PG_DELAY 8'hD4
`define PGFC_CMD_RAMP_GAIN 8'hD5
`define PGFC_CMD_COIL 8'hD6
`define PGFC_CMD_SNAP_MASK 8'hD7
`define PGFC_CMD_OVUV_CTRL 8'hD8
// field positions
`define PGFC_RAIL_ID_LSB 8
`define PGFC_PHASE_POS_LSB 13
`define PGFC_CROWBAR_BIT 7
// writable bit masks, unassigned bits read zero
`define PGFC_GROUP_CFG_MASK 16'hFF07
`define PGFC_SNAP_MASK_MASK 16'h3CFF
`define PGFC_OVUV_MASK 8'h8F
// reset values
`define PGFC_GROUP_CFG_RST 16'h0000
`define PGFC_PG_DELAY_RST 16'h0000
`define PGFC_RAMP_GAIN_RST 8'h01
`define PGFC_COIL_RST 16'h0000
`define PGFC_SNAP_MASK_RST 16'h0000
`define PGFC_OVUV_RST 8'h00
// timing
`define PGFC_MS_NS 32'h000F4240
`define PGFC_CLK_NS 32'h00000004
`define PGFC_CYC_PER_MS (`PGFC_MS_NS / `PGFC_CLK_NS)
// sized to the millisecond counter so the clamp needs no truncation
`define PGFC_PG_DELAY_MAX_MS 16'h1388
`endif

// ### design/pgfc_regs.v
// register bank for group bus, power-good delay, ramp, coil, snapshot mask and ov/uv control
`timescale 1ns/100ps
`include "pgfc_consts.vh"

module pgfc_regs #(
    parameter CYC_PER_MS = `PGFC_CYC_PER_MS
) (
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // command port from the transaction engine
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_cmd,
    input wire [15:0] i_wdata,
    output reg [15:0] o_rdata,
    output reg o_rvalid,
    output reg o_cmd_err,
    // regulator status
    input wire i_above_pg_on,
    input wire i_out_enable,
    input wire i_vout_over,
    input wire i_vout_under,
    input wire i_check,
    input wire [15:0] i_fault_evt,
    // control outputs
    output reg o_power_good_pin,
    output reg o_share_ramp_mode,
    output reg o_soft_off_allowed,
    output reg [7:0] o_ramp_gain,
    output reg [4:0] o_rail_id,
    output reg [3:0] o_phase_pos,
    output reg [3:0] o_phase_count,
    output reg [15:0] o_coil_uh,
    output reg o_snapshot_req,
    output reg [15:0] o_snapshot_cause,
    output reg o_over_voltage_fault,
    output reg o_under_voltage_fault,
    output reg o_low_side_on
);

////////////////////////////////////////////////////////////////////////////////
// helper functions

// linear11 value to whole units, rounded half up; negative values give zero
function [15:0] pgfc_lin_round;
    input [15:0] lin;
    reg [4:0] e;
    reg [10:0] m;
    reg [31:0] v;
    reg [4:0] sh;
    begin
        e = lin[15:11];
        m = lin[10:0];
        v = 32'h0;
        sh = 5'h00;
        if (m[10]) begin
            pgfc_lin_round = 16'h0;
        end else if (!e[4]) begin
            v = {21'h0, m} << e[3:0];
            pgfc_lin_round = (v[31:16] != 16'h0) ? 16'hFFFF : v[15:0];
        end else begin
            // five bits of shift so that an exponent of -16 is not taken as zero
            sh = 5'h00 - e;
            v = (({21'h0, m} << 1) >> sh) + 32'h1;
            pgfc_lin_round = v[16:1];
        end
    end
endfunction

// phase count code: odd codes 1,3,5,7 give 2,4,6,8; others invalid (zero)
function [3:0] pgfc_phases;
    input [2:0] code;
    begin
        if (code[0]) begin
            // each odd code sits one below the phase count it names
            pgfc_phases = {1'b0, code} + 4'h1;
        end else begin
            pgfc_phases = 4'h0;
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers

reg [15:0] group_rail_phase_config_r;
reg [15:0] power_good_delay_ms_r;
reg [7:0] shared_ramp_gain_r;
reg [15:0] coil_value_uh_r;
reg [15:0] snapshot_trigger_mask_r;
reg [7:0] output_voltage_fault_control_r;
wire cmd_known;

assign cmd_known = (i_cmd == `PGFC_CMD_GROUP_CFG) || (i_cmd == `PGFC_CMD_PG_DELAY) ||
    (i_cmd == `PGFC_CMD_RAMP_GAIN) || (i_cmd == `PGFC_CMD_COIL) ||
    (i_cmd == `PGFC_CMD_SNAP_MASK) || (i_cmd == `PGFC_CMD_OVUV_CTRL);

// the bank only stores what the host wrote; each field takes effect in the
// sections below, one registered stage after the write
// register writes; unassigned bits are masked so they never reach logic
always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        group_rail_phase_config_r <= `PGFC_GROUP_CFG_RST;
        power_good_delay_ms_r <= `PGFC_PG_DELAY_RST;
        shared_ramp_gain_r <= `PGFC_RAMP_GAIN_RST;
        coil_value_uh_r <= `PGFC_COIL_RST;
        snapshot_trigger_mask_r <= `PGFC_SNAP_MASK_RST;
        output_voltage_fault_control_r <= `PGFC_OVUV_RST;
    end else if (i_wr) begin
        if (i_cmd == `PGFC_CMD_GROUP_CFG) begin
            group_rail_phase_config_r <= i_wdata & `PGFC_GROUP_CFG_MASK;
        end else if (i_cmd == `PGFC_CMD_PG_DELAY) begin
            power_good_delay_ms_r <= i_wdata;
        end else if (i_cmd == `PGFC_CMD_RAMP_GAIN) begin
            shared_ramp_gain_r <= i_wdata[7:0];
        end else if (i_cmd == `PGFC_CMD_COIL) begin
            coil_value_uh_r <= i_wdata;
        end else if (i_cmd == `PGFC_CMD_SNAP_MASK) begin
            snapshot_trigger_mask_r <= i_wdata & `PGFC_SNAP_MASK_MASK;
        end else if (i_cmd == `PGFC_CMD_OVUV_CTRL) begin
            output_voltage_fault_control_r <= i_wdata[7:0] & `PGFC_OVUV_MASK;
        end
    end
end

// read port: answer one cycle after the strobe, zero and error on unknown command
// a byte register answers with its upper byte zero
always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        o_rdata <= 16'h0000;
        o_rvalid <= 1'b0;
        o_cmd_err <= 1'b0;
    end else begin
        o_rvalid <= i_rd;
        o_cmd_err <= (i_rd || i_wr) && !cmd_known;
        if (!i_rd) begin
            o_rdata <= o_rdata;
        end else if (i_cmd == `PGFC_CMD_GROUP_CFG) begin
            o_rdata <= group_rail_phase_config_r;
        end else if (i_cmd == `PGFC_CMD_PG_DELAY) begin
            o_rdata <= power_good_delay_ms_r;
        end else if (i_cmd == `PGFC_CMD_RAMP_GAIN) begin
            o_rdata <= {8'h00, shared_ramp_gain_r};
        end else if (i_cmd == `PGFC_CMD_COIL) begin
            o_rdata <= coil_value_uh_r;
        end else if (i_cmd == `PGFC_CMD_SNAP_MASK) begin
            o_rdata <= snapshot_trigger_mask_r;
        end else if (i_cmd == `PGFC_CMD_OVUV_CTRL) begin
            o_rdata <= {8'h00, output_voltage_fault_control_r};
        end else begin
            o_rdata <= 16'h0000;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// group configuration decode

// every derived output is registered so no logic follows a flop at the top;
// the cost is one more cycle between a write and its effect
wire [3:0] phase_count_dec;
wire sharing;

assign phase_count_dec = pgfc_phases(group_rail_phase_config_r[2:0]);
// a valid phase count means this rail shares current with peers
assign sharing = (phase_count_dec != 4'h0);

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        o_rail_id <= 5'h00;
        o_phase_pos <= 4'h1;
        o_phase_count <= 4'h0;
        o_ramp_gain <= `PGFC_RAMP_GAIN_RST;
        o_coil_uh <= 16'h0000;
        o_soft_off_allowed <= 1'b1;
    end else begin
        o_rail_id <= group_rail_phase_config_r[`PGFC_RAIL_ID_LSB +: 5];
        o_phase_pos <= {1'b0, group_rail_phase_config_r[`PGFC_PHASE_POS_LSB +: 3]}
            + 4'h1;
        o_phase_count <= phase_count_dec;
        o_ramp_gain <= shared_ramp_gain_r;
        o_coil_uh <= pgfc_lin_round(coil_value_uh_r);
        o_soft_off_allowed <= !sharing;
    end
end

////////////////////////////////////////////////////////////////////////////////
// power-good delay; ms counter plus cycle prescaler

// the prescaler counts the cycles of one millisecond and the ms counter counts those;
// dropping below threshold or disabling the output restarts both, so a dip
// below the threshold always costs the whole delay again
wire [15:0] pg_round_ms;
wire [15:0] pg_target_ms;
reg [31:0] pg_pre_r;
reg [15:0] pg_ms_r;

assign pg_round_ms = pgfc_lin_round(power_good_delay_ms_r);
// values above the documented ceiling clamp so the pin is never held off forever
assign pg_target_ms = (pg_round_ms > `PGFC_PG_DELAY_MAX_MS) ?
    `PGFC_PG_DELAY_MAX_MS : pg_round_ms;

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        pg_pre_r <= 32'h0;
        pg_ms_r <= 16'h0;
        o_power_good_pin <= 1'b0;
        o_share_ramp_mode <= 1'b0;
    end else if (!i_above_pg_on || !i_out_enable) begin
        pg_pre_r <= 32'h0;
        pg_ms_r <= 16'h0;
        o_power_good_pin <= 1'b0;
        o_share_ramp_mode <= sharing && i_out_enable;
    end else if (pg_ms_r >= pg_target_ms) begin
        o_power_good_pin <= 1'b1;
        o_share_ramp_mode <= 1'b0;
    end else if (pg_pre_r == CYC_PER_MS - 1) begin
        pg_pre_r <= 32'h0;
        pg_ms_r <= pg_ms_r + 16'h1;
    end else begin
        pg_pre_r <= pg_pre_r + 32'h1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// output over/under voltage violation counting and crowbar

// counters saturate at the limit so a long violation run cannot wrap and
// look like a fresh short run; faults stay until the output is disabled
reg [4:0] ov_cnt_r;
reg [4:0] uv_cnt_r;
wire [4:0] viol_lim;

assign viol_lim = {1'b0, output_voltage_fault_control_r[3:0]} + 5'h1;

// counts consecutive checks; a clean check restarts the run
always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        ov_cnt_r <= 5'h0;
        uv_cnt_r <= 5'h0;
        o_over_voltage_fault <= 1'b0;
        o_under_voltage_fault <= 1'b0;
        o_low_side_on <= 1'b0;
    end else if (!i_out_enable) begin
        ov_cnt_r <= 5'h0;
        uv_cnt_r <= 5'h0;
        o_over_voltage_fault <= 1'b0;
        o_under_voltage_fault <= 1'b0;
        o_low_side_on <= 1'b0;
    end else if (i_check) begin
        ov_cnt_r <= i_vout_over ? ((ov_cnt_r < viol_lim) ? ov_cnt_r + 5'h1 : ov_cnt_r) : 5'h0;
        uv_cnt_r <= i_vout_under ? ((uv_cnt_r < viol_lim) ? uv_cnt_r + 5'h1 : uv_cnt_r) : 5'h0;
        if (i_vout_over && ov_cnt_r + 5'h1 >= viol_lim) begin
            o_over_voltage_fault <= 1'b1;
            // crowbar follows the control bit held when the fault fires
            o_low_side_on <= output_voltage_fault_control_r[`PGFC_CROWBAR_BIT];
        end
        if (i_vout_under && uv_cnt_r + 5'h1 >= viol_lim) begin
            o_under_voltage_fault <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// snapshot trigger: unmasked fault events request a store write

// reserved bits are masked again here so a stray event on an unused
// line can never request a store write
wire [15:0] snap_hit;

assign snap_hit = i_fault_evt & ~snapshot_trigger_mask_r & `PGFC_SNAP_MASK_MASK;

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        o_snapshot_req <= 1'b0;
        o_snapshot_cause <= 16'h0000;
    end else begin
        o_snapshot_req <= (snap_hit != 16'h0000);
        o_snapshot_cause <= snap_hit;
    end
end

endmodule // pgfc_regs

// ### tb/pgfc_regs_asserts.sv
// port checker for the configuration register bank
`timescale 1ns/100ps
module pgfc_regs_asserts (
    // watched ports
    input wire i_clk,
    input wire i_rst,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_cmd,
    input wire [15:0] i_wdata,
    input wire [15:0] o_rdata,
    input wire o_cmd_err,
    input wire i_above_pg_on,
    input wire i_check,
    input wire i_vout_over,
    input wire o_power_good_pin,
    input wire o_share_ramp_mode,
    input wire o_soft_off_allowed,
    input wire [7:0] o_ramp_gain,
    input wire [4:0] o_rail_id,
    input wire [3:0] o_phase_pos,
    input wire [3:0] o_phase_count,
    input wire o_over_voltage_fault,
    input wire o_low_side_on
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////
    // copies land two edges after the write, so a back-to-back write cannot hide a slip
    rail_id_copy_a: assert property (i_wr && i_cmd == 8'hD3 |-> ##2
        o_rail_id == $past(i_wdata[12:8], 2)) else $error("rail id copy wrong");
    phase_pos_copy_a: assert property (i_wr && i_cmd == 8'hD3 |-> ##2
        o_phase_pos == {1'b0, $past(i_wdata[15:13], 2)} + 4'h1) else $error("phase pos wrong");
    phase_count_decode_a: assert property (i_wr && i_cmd == 8'hD3 |-> ##2
        o_phase_count == ($past(i_wdata[0], 2) ? {1'b0, $past(i_wdata[2:0], 2)} + 4'h1 : 4'h0))
        else $error("phase count wrong");
    ramp_gain_copy_a: assert property (i_wr && i_cmd == 8'hD5 |-> ##2
        o_ramp_gain == $past(i_wdata[7:0], 2)) else $error("ramp gain wrong");
    pg_drop_a: assert property (!i_above_pg_on |=> !o_power_good_pin)
        else $error("power good held below threshold");
    pg_ends_ramp_a: assert property (o_power_good_pin |-> !o_share_ramp_mode)
        else $error("shared ramp still on with power good");
    no_soft_off_a: assert property (o_phase_count != 0 && $past(o_phase_count) != 0
        |-> !o_soft_off_allowed) else $error("soft off allowed while sharing");
    ov_on_check_a: assert property ($rose(o_over_voltage_fault)
        |-> $past(i_check && i_vout_over)) else $error("ov fault without a violating check");
    crowbar_with_ov_a: assert property ($rose(o_low_side_on) |-> o_over_voltage_fault)
        else $error("low side on without ov fault");
    unknown_cmd_a: assert property (i_rd && (i_cmd < 8'hD3 || i_cmd > 8'hD8)
        |=> o_cmd_err && o_rdata == 16'h0000) else $error("unknown read not refused");
endmodule // pgfc_regs_asserts
bind pgfc_regs pgfc_regs_asserts pgfc_regs_asserts_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_wr(i_wr), .i_rd(i_rd), .i_cmd(i_cmd), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_cmd_err(o_cmd_err), .i_above_pg_on(i_above_pg_on), .i_check(i_check),
    .i_vout_over(i_vout_over), .o_power_good_pin(o_power_good_pin),
    .o_share_ramp_mode(o_share_ramp_mode), .o_soft_off_allowed(o_soft_off_allowed),
    .o_ramp_gain(o_ramp_gain), .o_rail_id(o_rail_id), .o_phase_pos(o_phase_pos),
    .o_phase_count(o_phase_count), .o_over_voltage_fault(o_over_voltage_fault),
    .o_low_side_on(o_low_side_on));

// ### tb/pgfc_sense_model.sv
// output comparator model: spaced check pulses carrying commanded violations
`timescale 1ns/100ps
module pgfc_sense_model (
    // command from the bench
    input wire i_clk,
    input wire i_go,
    input wire [4:0] i_num,
    input wire i_ov,
    input wire i_uv,
    // comparator side
    output wire o_check,
    output wire o_over,
    output wire o_under
);
    logic [4:0] left_r = 5'h00;
    logic [1:0] ph_r = 2'h0;
    logic check_r = 1'b0;
    logic over_r = 1'b0;
    logic under_r = 1'b0;
    assign o_check = check_r;
    assign o_over = over_r;
    assign o_under = under_r;
    // levels only mean something at a check; between checks they wander on purpose
    always @(negedge i_clk) begin
        ph_r <= ph_r + 2'h1;
        if (i_go) left_r <= i_num;
        if (left_r != 0 && ph_r == 2'h3) begin
            check_r <= 1'b1;
            over_r <= i_ov;
            under_r <= i_uv;
            left_r <= left_r - 5'h01;
        end else begin
            check_r <= 1'b0;
            over_r <= ~over_r;
            under_r <= ~under_r;
        end
    end
endmodule // pgfc_sense_model

// ### tb/test_pgfc_regs.sv
// self-checking bench for the configuration register bank
`timescale 1ns/100ps
module test_pgfc_regs;
    logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_above_pg_on = 0, i_out_enable = 0;
    logic [7:0] i_cmd = 8'h00;
    logic [15:0] i_wdata = 16'h0000, i_fault_evt = 16'h0000, q, e, m;
    logic i_vout_over, i_vout_under, i_check, err, go = 0, gov = 0, guv = 0;
    logic [4:0] gn = 5'h00;
    wire [15:0] o_rdata, o_coil_uh, o_snapshot_cause;
    wire [7:0] o_ramp_gain;
    wire [4:0] o_rail_id;
    wire [3:0] o_phase_pos, o_phase_count;
    wire o_rvalid, o_cmd_err, o_power_good_pin, o_share_ramp_mode, o_soft_off_allowed;
    wire o_snapshot_req, o_over_voltage_fault, o_under_voltage_fault, o_low_side_on;
    int n_fail = 0, total_checks = 0, n;
    ////////////////////////////////////////
    pgfc_regs #(.CYC_PER_MS(4)) pgfc_regs_inst (.i_clk(i_clk), .i_rst(i_rst), .i_wr(i_wr),
        .i_rd(i_rd), .i_cmd(i_cmd), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
        .o_cmd_err(o_cmd_err), .i_above_pg_on(i_above_pg_on), .i_out_enable(i_out_enable),
        .i_vout_over(i_vout_over), .i_vout_under(i_vout_under), .i_check(i_check),
        .i_fault_evt(i_fault_evt), .o_power_good_pin(o_power_good_pin),
        .o_share_ramp_mode(o_share_ramp_mode), .o_soft_off_allowed(o_soft_off_allowed),
        .o_ramp_gain(o_ramp_gain), .o_rail_id(o_rail_id), .o_phase_pos(o_phase_pos),
        .o_phase_count(o_phase_count), .o_coil_uh(o_coil_uh), .o_snapshot_req(o_snapshot_req),
        .o_snapshot_cause(o_snapshot_cause), .o_over_voltage_fault(o_over_voltage_fault),
        .o_under_voltage_fault(o_under_voltage_fault), .o_low_side_on(o_low_side_on));
    pgfc_sense_model pgfc_sense_model_inst (.i_clk(i_clk), .i_go(go), .i_num(gn), .i_ov(gov),
        .i_uv(guv), .o_check(i_check), .o_over(i_vout_over), .o_under(i_vout_under));
    always #2 i_clk = ~i_clk;
    // compare, verdict and bus tasks
    task chk(input [15:0] s, input [15:0] x);
        total_checks++;
        if (s !== x) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, x);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task wr(input [7:0] c, input [15:0] d);
        @(negedge i_clk) {i_wr, i_cmd, i_wdata} = {1'b1, c, d};
        @(negedge i_clk) i_wr = 0;
    endtask
    task rd(input [7:0] c, output [15:0] r);
        @(negedge i_clk) {i_rd, i_cmd} = {1'b1, c};
        @(negedge i_clk) i_rd = 0;
        r = o_rdata;
        err = o_cmd_err;
        chk(o_rvalid, 1);
    endtask
    // nonblocking, so the model reads the command one edge later without a race
    task burst(input [4:0] k, input ov, input uv);
        @(negedge i_clk) {gn, gov, guv, go} <= {k, ov, uv, 1'b1};
        @(negedge i_clk) go <= 1'b0;
        repeat (4 * k + 6) @(negedge i_clk);
    endtask
    // rounded milliseconds of a power-good delay, clamped at the top
    function int lms(input [15:0] v);
        int mm, x;
        mm = $signed(v[10:0]);
        x = $signed(v[15:11]);
        if (mm < 0) return 0;
        lms = x >= 0 ? mm << x : (mm + (1 << (-x - 1))) >> -x;
        if (lms > 5000) lms = 5000;
    endfunction
    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h1716eb01));
        repeat (6) @(posedge i_clk);
        @(negedge i_clk) i_rst = 0;
        for (int c = 0; c < 6; c++) begin
            rd(8'hD3 + 8'(c), q);
            chk(q, c == 2 ? 16'h0001 : 16'h0000);
        end
        $display("reset values done");
        for (int k = 0; k < 8; k++) begin
            e = $urandom;
            e[2:0] = 3'(k);
            wr(8'hD3, e);
            rd(8'hD3, q);
            chk(q, e & 16'hFF07);
            chk(o_rail_id, e[12:8]);
            chk(o_phase_pos, e[15:13] + 4'h1);
            chk(o_phase_count, e[0] ? e[2:0] + 4'h1 : 4'h0);
            chk(o_soft_off_allowed, !e[0]);
        end
        e = $urandom;
        wr(8'hD5, e);
        rd(8'hD5, q);
        chk(q, e & 16'h00FF);
        chk(o_ramp_gain, e[7:0]);
        wr(8'hD6, 16'hF80B);
        @(negedge i_clk);
        chk(o_coil_uh, 16'h0006);
        wr(8'hD9, 16'hFFFF);
        chk(o_cmd_err, 1);
        rd(8'hD9, q);
        chk(q, 16'h0000);
        chk(err, 1);
        $display("register access done");
        for (int j = 0; j < 2; j++) begin
            m = j ? 16'hFFFF : 16'($urandom);
            wr(8'hD7, m);
            rd(8'hD7, q);
            chk(q, m & 16'h3CFF);
            repeat (20) begin
                e = $urandom;
                @(negedge i_clk) i_fault_evt = e;
                @(negedge i_clk) i_fault_evt = 16'h0000;
                chk(o_snapshot_req, |(e & ~m & 16'h3CFF));
                chk(o_snapshot_cause, e & ~m & 16'h3CFF);
            end
        end
        $display("snapshot mask done");
        // phase code 1 names two phases, so this rail shares and starts in shared ramp mode
        wr(8'hD3, 16'h0001);
        wr(8'hD4, 16'hF805);
        @(negedge i_clk) i_out_enable = 1;
        repeat (2) @(negedge i_clk);
        chk(o_share_ramp_mode, 1);
        i_above_pg_on = 1;
        n = 0;
        while (o_power_good_pin !== 1'b1 && n < 100) begin
            @(negedge i_clk) n++;
        end
        chk(n >= lms(16'hF805) * 4 && n <= lms(16'hF805) * 4 + 3, 1);
        chk(o_share_ramp_mode, 0);
        chk(n < 100, 1);
        @(negedge i_clk) i_above_pg_on = 0;
        @(negedge i_clk) chk(o_power_good_pin, 0);
        $display("power good done");
        wr(8'hD8, 16'hFF83);
        rd(8'hD8, q);
        chk(q, 16'h0083);
        burst(3, 1, 0);
        chk(o_over_voltage_fault, 0);
        burst(1, 1, 0);
        chk({o_over_voltage_fault, o_low_side_on}, 2'b11);
        @(negedge i_clk) i_out_enable = 0;
        @(negedge i_clk) i_out_enable = 1;
        wr(8'hD8, 16'h0002);
        burst(3, 0, 1);
        chk({o_under_voltage_fault, o_low_side_on}, 2'b10);
        burst(3, 1, 0);
        chk({o_over_voltage_fault, o_low_side_on}, 2'b10);
        $display("voltage fault done");
        test_done;
    end
endmodule // test_pgfc_regs
